//--- flash_self_prog_pkg.sv
// Constants, types and register map for the flash self-programming controller.
// Assumes a word-addressed program flash and a classic Wishbone register bus.
package flash_self_prog_pkg;

  // ----------------------------------------------------------------------
  // Flash geometry
  // ----------------------------------------------------------------------
  localparam int FLASH_AW = 12;
  localparam logic [FLASH_AW-1:0] FLASH_TOP = 12'hFFF;
  localparam logic [FLASH_AW-1:0] APP_RESET_ADDR = 12'h000;
  // Fixed first word of the stalling section.
  localparam logic [FLASH_AW-1:0] STALL_BASE = 12'hC00;
  // Boot section sizes in words, selected by the boot size fuses.
  localparam logic [FLASH_AW-1:0] BOOT_WORDS_00 = 12'h400;
  localparam logic [FLASH_AW-1:0] BOOT_WORDS_01 = 12'h200;
  localparam logic [FLASH_AW-1:0] BOOT_WORDS_10 = 12'h100;
  localparam logic [FLASH_AW-1:0] BOOT_WORDS_11 = 12'h080;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int WB_AW = 8;
  localparam logic [WB_AW-1:0] FLASH_STORE_CTRL_STATUS_OFS = 8'h00;
  localparam logic [WB_AW-1:0] LOCK_BITS_OFS = 8'h04;
  localparam logic [WB_AW-1:0] SECTION_CFG_OFS = 8'h08;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Control and status fields.
  localparam int CS_BUSY_BIT = 0;
  localparam int CS_ACTIVE_BIT = 1;
  localparam int CS_STALL_BIT = 2;
  localparam int CS_REJECT_BIT = 3;
  // Lock bits fields: application pair then boot pair.
  localparam int LK_APP_LSB = 0;
  localparam int LK_BOOT_LSB = 2;
  localparam logic [1:0] LOCK_PAIR_RESET = 2'h3;
  // Section configuration fields.
  localparam int CFG_BOOT_SIZE_FUSES_LSB = 0;
  localparam int CFG_VECT_BIT = 2;
  localparam int CFG_BOOT_START_LSB = 16;

  // Lock pair meaning: low bit 0 blocks stores, high bit 0 blocks loads.
  localparam int LOCK_STORE_BIT = 0;
  localparam int LOCK_LOAD_BIT = 1;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic erase;
    logic [FLASH_AW-1:0] addr;
  } flash_cmd_s;

  typedef struct packed {
    logic [1:0] boot_pair;
    logic [1:0] app_pair;
  } lock_bits_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONC,
    ST_STALL
  } prog_state_e;

endpackage

//--- boot_flash_self_program_control.sv
// Self-programming controller: gates flash stores by code location,
// runs page erase and write, and guards reads during programming.
// Assumes the flash macro and the core run on REF_CLK; fuses are static.
//
// Function
// - A flash store fetched from the application section is ignored.
// - Erase or write starts only for stores executed from the boot section.
// - A store from the boot section may target any flash page.
// - Programming the concurrent-read section keeps the CPU running.
// - Programming the stalling section halts the CPU throughout.
// - Concurrent-read section yields no valid code while programming.
// - Busy flag reads one while the concurrent-read section is blocked.
// - Section stays blocked after programming until software clears busy.
// - The boot section always lies inside the stalling section.
// - Boot boundary follows fuses; concurrent/stalling boundary is fixed.
// - Application and boot lock pairs are independent.
// - A fuse selects the reset vector target.
// - Application lock pair encodes four protection levels.
// - Boot lock pair encodes four protection levels.
// - Lock bits are only programmed by software; chip erase clears them.
// - Reset vector is 0x0000 when fuse is one, boot start when zero.
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module boot_flash_self_program_control
  import flash_self_prog_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WB_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic STORE_REQ,
  input wire logic [FLASH_AW-1:0] STORE_PC,
  input wire flash_cmd_s STORE_CMD,
  input wire logic LOAD_REQ,
  input wire logic [FLASH_AW-1:0] LOAD_PC,
  input wire logic [FLASH_AW-1:0] LOAD_ADDR,
  input wire logic [FLASH_AW-1:0] FETCH_ADDR,
  input wire logic [FLASH_AW-1:0] EXEC_PC,
  input wire logic VECTORS_IN_BOOT,
  input wire logic FLASH_DONE,
  input wire logic CHIP_ERASE,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic BOOT_VECTOR_FUSE,
  output flash_cmd_s FLASH_CMD,
  output logic FLASH_START,
  output logic CPU_STALL,
  output logic FETCH_INVALID,
  output logic LOAD_DENY,
  output logic IRQ_BLOCK,
  output logic STORE_REJECT,
  output logic [FLASH_AW-1:0] RESET_VECTOR
);

  // ----------------------------------------------------------------------
  // Fuse capture
  // ----------------------------------------------------------------------
  logic fuse_valid_r;
  logic [1:0] boot_size_fuses_r;
  logic vect_fuse_r;

  // Fuses are caught by the first clocked cycle after reset release.
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      fuse_valid_r <= 1'b0;
      boot_size_fuses_r <= 2'h0;
      vect_fuse_r <= 1'b1;
    end else if (!fuse_valid_r) begin
      fuse_valid_r <= 1'b1;
      boot_size_fuses_r <= BOOT_SIZE_FUSES;
      vect_fuse_r <= BOOT_VECTOR_FUSE;
    end
  end

  // ----------------------------------------------------------------------
  // Section decode
  // ----------------------------------------------------------------------
  logic [FLASH_AW-1:0] boot_words;
  logic [FLASH_AW-1:0] boot_start;
  logic [FLASH_AW-1:0] reset_vec_nxt;
  logic store_pc_boot;
  logic store_tgt_boot;
  logic store_tgt_stall;
  logic load_pc_boot;
  logic load_tgt_boot;
  logic load_tgt_conc;
  logic fetch_conc;
  logic exec_boot;

  assign boot_words = (boot_size_fuses_r == 2'h0) ? BOOT_WORDS_00 :
                      (boot_size_fuses_r == 2'h1) ? BOOT_WORDS_01 :
                      (boot_size_fuses_r == 2'h2) ? BOOT_WORDS_10 : BOOT_WORDS_11;
  // Boot start moves with the fuses; the largest size equals the stalling
  // section, so the boot section never reaches below the fixed boundary.
  assign boot_start = FLASH_TOP - boot_words + 12'h001;
  assign reset_vec_nxt = vect_fuse_r ? APP_RESET_ADDR : boot_start;

  assign store_pc_boot = (STORE_PC >= boot_start);
  assign store_tgt_boot = (STORE_CMD.addr >= boot_start);
  assign store_tgt_stall = (STORE_CMD.addr >= STALL_BASE);
  assign load_pc_boot = (LOAD_PC >= boot_start);
  assign load_tgt_boot = (LOAD_ADDR >= boot_start);
  assign load_tgt_conc = (LOAD_ADDR < STALL_BASE);
  assign fetch_conc = (FETCH_ADDR < STALL_BASE);
  assign exec_boot = (EXEC_PC >= boot_start);

  // ----------------------------------------------------------------------
  // Lock bits
  // ----------------------------------------------------------------------
  lock_bits_s lock_r;
  lock_bits_s lock_nxt;
  logic lock_wr;
  logic app_store_lock;
  logic app_load_lock;
  logic boot_store_lock;
  logic boot_load_lock;

  assign app_store_lock = !lock_r.app_pair[LOCK_STORE_BIT];
  assign app_load_lock = !lock_r.app_pair[LOCK_LOAD_BIT];
  assign boot_store_lock = !lock_r.boot_pair[LOCK_STORE_BIT];
  assign boot_load_lock = !lock_r.boot_pair[LOCK_LOAD_BIT];

  // Writes can only program bits to zero; each pair has its own field.
  assign lock_nxt.app_pair = lock_r.app_pair &
      WB_DAT_I[LK_APP_LSB +: 2];
  assign lock_nxt.boot_pair = lock_r.boot_pair &
      WB_DAT_I[LK_BOOT_LSB +: 2];

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      lock_r <= {LOCK_PAIR_RESET, LOCK_PAIR_RESET};
    end else if (CHIP_ERASE) begin
      lock_r <= {LOCK_PAIR_RESET, LOCK_PAIR_RESET};
    end else if (lock_wr) begin
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Store acceptance
  // ----------------------------------------------------------------------
  prog_state_e state_r;
  prog_state_e state_nxt;
  logic store_ok;
  logic store_locked;
  logic accept;
  logic reject;

  assign store_locked = store_tgt_boot ? boot_store_lock : app_store_lock;
  // Only boot-resident code may program; any page is a legal target.
  assign store_ok = store_pc_boot && !store_locked;
  assign accept = STORE_REQ && (state_r == ST_IDLE) && store_ok;
  assign reject = STORE_REQ && !accept;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = store_tgt_stall ? ST_STALL : ST_CONC;
        end
      end
      ST_CONC: begin
        if (FLASH_DONE) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_STALL: begin
        if (FLASH_DONE) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Concurrent-section busy flag
  // ----------------------------------------------------------------------
  logic busy_r;
  logic busy_nxt;
  logic busy_set;
  logic busy_clr;
  logic cs_wr;

  assign busy_set = accept && !store_tgt_stall;
  // Clearing is refused while the operation is still running.
  assign busy_clr = cs_wr && WB_SEL_I[0] && WB_DAT_I[CS_BUSY_BIT] &&
                    (state_r != ST_CONC);
  // Set wins over a clear in the same cycle.
  assign busy_nxt = busy_set | (busy_r & !busy_clr);

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read guarding and interrupt masking
  // ----------------------------------------------------------------------
  logic conc_blocked;
  logic load_lock_hit;
  logic irq_block_nxt;

  assign conc_blocked = busy_r || (state_r == ST_CONC);
  // Boot-resident loads into the application, or application loads into
  // the boot section, follow the load-lock bit of the target pair.
  assign load_lock_hit = load_pc_boot ?
      (!load_tgt_boot && app_load_lock) :
      (load_tgt_boot && boot_load_lock);
  assign irq_block_nxt = VECTORS_IN_BOOT ?
      (!exec_boot && app_load_lock) :
      (exec_boot && boot_load_lock);

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  logic wb_req;
  logic wb_wr;
  logic ack_nxt;
  logic [31:0] dat_o_nxt;
  logic sel_cs;
  logic sel_lock;
  logic sel_cfg;
  logic [31:0] rd_data;
  logic [31:0] cs_word;
  logic [31:0] lock_word;
  logic [31:0] cfg_word;

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Writes land on the edge at which the master samples ack, while it still
  // holds address and data, so a write takes effect exactly once.
  assign wb_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
  // Register map: 0x00 control and status (bit 0 busy, write one to clear;
  // bit 1 active; bit 2 stall; bit 3 store reject), 0x04 lock pairs (a
  // write can only program bits to zero), 0x08 fuse and section view.
  assign sel_cs = (WB_ADR_I == FLASH_STORE_CTRL_STATUS_OFS);
  assign sel_lock = (WB_ADR_I == LOCK_BITS_OFS);
  assign sel_cfg = (WB_ADR_I == SECTION_CFG_OFS);
  assign cs_wr = wb_wr && sel_cs;
  assign lock_wr = wb_wr && sel_lock && WB_SEL_I[0];

  assign cs_word = {28'h0000000, STORE_REJECT, CPU_STALL,
                    (state_r != ST_IDLE), busy_r};
  assign lock_word = {28'h0000000, lock_r.boot_pair, lock_r.app_pair};
  assign cfg_word = {4'h0, boot_start, 13'h0000, vect_fuse_r, boot_size_fuses_r};
  assign rd_data = sel_cs ? cs_word :
                   sel_lock ? lock_word :
                   sel_cfg ? cfg_word : UNMAPPED_READ;
  assign ack_nxt = wb_req;
  assign dat_o_nxt = wb_req ? rd_data : 32'h0000_0000;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= ack_nxt;
      WB_DAT_O <= dat_o_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  logic cpu_stall_nxt;
  logic fetch_invalid_nxt;
  logic load_deny_nxt;
  logic store_reject_nxt;

  // The stall is held from acceptance through the done cycle.
  assign cpu_stall_nxt = (accept && store_tgt_stall) ||
                         (state_r == ST_STALL && !FLASH_DONE);
  assign fetch_invalid_nxt = fetch_conc && conc_blocked;
  assign load_deny_nxt = LOAD_REQ && ((load_tgt_conc && conc_blocked) ||
                                      load_lock_hit);
  // The reject flag keeps its value between store instructions.
  assign store_reject_nxt = STORE_REQ ? reject : STORE_REJECT;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      FLASH_CMD <= '0;
      FLASH_START <= 1'b0;
    end else begin
      FLASH_START <= accept;
      if (accept) begin
        FLASH_CMD <= STORE_CMD;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      CPU_STALL <= 1'b0;
      STORE_REJECT <= 1'b0;
    end else begin
      CPU_STALL <= cpu_stall_nxt;
      STORE_REJECT <= store_reject_nxt;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      FETCH_INVALID <= 1'b0;
      LOAD_DENY <= 1'b0;
      IRQ_BLOCK <= 1'b0;
    end else begin
      FETCH_INVALID <= fetch_invalid_nxt;
      LOAD_DENY <= load_deny_nxt;
      IRQ_BLOCK <= irq_block_nxt;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      RESET_VECTOR <= APP_RESET_ADDR;
    end else begin
      RESET_VECTOR <= reset_vec_nxt;
    end
  end

endmodule

//--- flash_macro_model.sv
// Behavioural flash macro on the far side of the self-programming controller.
// Assumes start and done share the controller clock; the delay input sets the answer time.
`timescale 1ns/100ps
module flash_macro_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] delay,
  output logic done
);
  logic busy_r;
  logic [7:0] cnt_r;

  // Counts the delay after each start, then pulses done for one cycle.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        cnt_r <= delay;
      end else if (busy_r) begin
        if (cnt_r == 8'h00) begin
          done <= 1'b1;
          busy_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule

//--- flash_prog_monitor.sv
// Port checks for the flash self-programming controller.
// Assumes static fuses and a flash macro on the same clock.
`timescale 1ns/100ps
module flash_prog_monitor
  import flash_self_prog_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic STORE_REQ,
  input wire logic [FLASH_AW-1:0] STORE_PC,
  input wire logic LOAD_REQ,
  input wire logic [FLASH_AW-1:0] FETCH_ADDR,
  input wire logic FLASH_DONE,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic BOOT_VECTOR_FUSE,
  input wire flash_cmd_s FLASH_CMD,
  input wire logic FLASH_START,
  input wire logic CPU_STALL,
  input wire logic FETCH_INVALID,
  input wire logic LOAD_DENY,
  input wire logic STORE_REJECT,
  input wire logic [FLASH_AW-1:0] RESET_VECTOR
);
  logic [FLASH_AW-1:0] boot_start;
  assign boot_start = FLASH_TOP - (BOOT_WORDS_00 >> BOOT_SIZE_FUSES) + 12'h001;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  property p_app_store;
    STORE_REQ && STORE_PC < boot_start |=> STORE_REJECT && !FLASH_START;
  endproperty
  a_app_store: assert property (p_app_store) else $error("App store not ignored");
  property p_boot_start;
    FLASH_START |-> $past(STORE_REQ) && $past(STORE_PC) >= boot_start;
  endproperty
  a_boot_start: assert property (p_boot_start) else $error("Start without boot store");
  property p_conc_run;
    FLASH_START && FLASH_CMD.addr < STALL_BASE |-> !CPU_STALL;
  endproperty
  a_conc_run: assert property (p_conc_run) else $error("Stall on concurrent page");
  property p_stall_go;
    FLASH_START && FLASH_CMD.addr >= STALL_BASE |-> CPU_STALL;
  endproperty
  a_stall_go: assert property (p_stall_go) else $error("No stall on stalling page");
  property p_stall_hold;
    CPU_STALL && !FLASH_DONE |=> CPU_STALL;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("Stall dropped early");
  property p_stall_end;
    CPU_STALL && FLASH_DONE |=> !CPU_STALL;
  endproperty
  a_stall_end: assert property (p_stall_end) else $error("Stall kept after done");
  property p_fetch_blank;
    FETCH_INVALID |-> $past(FETCH_ADDR) < STALL_BASE;
  endproperty
  a_fetch_blank: assert property (p_fetch_blank) else $error("Stalling fetch blanked");
  property p_deny_cause;
    LOAD_DENY |-> $past(LOAD_REQ);
  endproperty
  a_deny_cause: assert property (p_deny_cause) else $error("Deny without load");
  property p_reset_vec;
    $past(NRST) && $past(NRST, 2) |-> RESET_VECTOR == (BOOT_VECTOR_FUSE ? 12'h000 : boot_start);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("Reset vector wrong");

  c_stall_op: cover property (FLASH_START && CPU_STALL);
  c_fetch_blank: cover property (FETCH_INVALID);
  c_load_deny: cover property (LOAD_DENY);
  c_reject: cover property (STORE_REJECT);
endmodule

bind boot_flash_self_program_control flash_prog_monitor mon_u (
  .REF_CLK(REF_CLK), .NRST(NRST), .STORE_REQ(STORE_REQ), .STORE_PC(STORE_PC),
  .LOAD_REQ(LOAD_REQ), .FETCH_ADDR(FETCH_ADDR), .FLASH_DONE(FLASH_DONE),
  .BOOT_SIZE_FUSES(BOOT_SIZE_FUSES), .BOOT_VECTOR_FUSE(BOOT_VECTOR_FUSE),
  .FLASH_CMD(FLASH_CMD), .FLASH_START(FLASH_START), .CPU_STALL(CPU_STALL),
  .FETCH_INVALID(FETCH_INVALID), .LOAD_DENY(LOAD_DENY), .STORE_REJECT(STORE_REJECT),
  .RESET_VECTOR(RESET_VECTOR));

//--- tb_top.sv
// Self-checking bench for the flash self-programming controller.
// Assumes the flash macro model answers starts; the bench plays core and software.
`timescale 1ns/100ps
module tb_top
  import flash_self_prog_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, st_req = 1'b0;
  logic ld_req = 1'b0, vib = 1'b0, chip_er = 1'b0, bvf = 1'b1, ack, f_done, f_start;
  logic stall, f_inv, ld_deny, irq_blk, st_rej;
  logic [7:0] adr = 8'h00, dly = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [11:0] st_pc = 12'h000, ld_pc = 12'h000, ld_adr = 12'h000, f_adr = 12'hC10;
  logic [11:0] x_pc = 12'h000, rst_vec;
  logic [1:0] bsz = 2'h0;
  flash_cmd_s st_cmd = 13'h0000, f_cmd;
  int errors = 0, checked = 0, cycles = 0;

  always #5 clk = ~clk;

  boot_flash_self_program_control dut_u (
    .REF_CLK(clk), .NRST(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .STORE_REQ(st_req), .STORE_PC(st_pc), .STORE_CMD(st_cmd), .LOAD_REQ(ld_req),
    .LOAD_PC(ld_pc), .LOAD_ADDR(ld_adr), .FETCH_ADDR(f_adr), .EXEC_PC(x_pc),
    .VECTORS_IN_BOOT(vib), .FLASH_DONE(f_done), .CHIP_ERASE(chip_er),
    .BOOT_SIZE_FUSES(bsz), .BOOT_VECTOR_FUSE(bvf), .FLASH_CMD(f_cmd),
    .FLASH_START(f_start), .CPU_STALL(stall), .FETCH_INVALID(f_inv),
    .LOAD_DENY(ld_deny), .IRQ_BLOCK(irq_blk), .STORE_REJECT(st_rej), .RESET_VECTOR(rst_vec));

  flash_macro_model flash_u (.ref_clk(clk), .nrst(rst_n), .start(f_start), .delay(dly),
    .done(f_done));

  // ----------------------------------------------------------------------
  // Shared drivers and comparisons
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic store(input logic [11:0] pc, input logic er, input logic [11:0] ta);
    @(posedge clk);
    st_pc <= pc;
    st_cmd <= {er, ta};
    st_req <= 1'b1;
    @(posedge clk);
    st_req <= 1'b0;
    #1;
  endtask
  task automatic wait_done();
    do @(posedge clk); while (f_done !== 1'b1);
    #1;
  endtask
  task automatic load(input logic [11:0] pc, input logic [11:0] a);
    @(posedge clk);
    ld_pc <= pc;
    ld_adr <= a;
    ld_req <= 1'b1;
    @(posedge clk);
    ld_req <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_fuses();
    logic [11:0] bs;
    for (int f = 0; f < 4; f++) begin
      bs = 12'hFFF - (12'h400 >> f) + 12'h001;
      @(posedge clk);
      rst_n <= 1'b0;
      bsz <= f[1:0];
      bvf <= f[0];
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("reset_vector", {20'h0, f[0] ? 12'h000 : bs}, {20'h0, rst_vec});
      wb(1'b0, 8'h08, 32'h0);
      chk("section_cfg", {4'h0, bs, 13'h0, f[0], f[1:0]}, rd);
      chkb("boot_in_stall", 1'b1, rd[27:16] >= STALL_BASE);
    end
  endtask
  task automatic t_app_store();
    store(12'hF7F, 1'b1, 12'h040);
    chkb("app_store_start", 1'b0, f_start);
    chkb("app_store_reject", 1'b1, st_rej);
  endtask
  task automatic t_conc();
    dly <= 8'h28;
    store(12'hF80, 1'b1, 12'h040);
    chkb("conc_start", 1'b1, f_start);
    chkb("conc_stall", 1'b0, stall);
    chk("conc_cmd", {19'h0, 1'b1, 12'h040}, {19'h0, f_cmd});
    @(posedge clk);
    f_adr <= 12'h010;
    tick();
    chkb("conc_fetch", 1'b1, f_inv);
    @(posedge clk);
    f_adr <= 12'hC10;
    tick();
    chkb("stall_fetch", 1'b0, f_inv);
    load(12'hF90, 12'h020);
    chkb("conc_load", 1'b1, ld_deny);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk("busy_running", 32'h3, rd & 32'hF);
    wait_done();
    wb(1'b0, 8'h00, 32'h0);
    chk("busy_after_done", 32'h1, rd & 32'hF);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk("busy_cleared", 32'h0, rd & 32'hF);
    f_adr <= 12'h010;
    tick();
    chkb("fetch_open", 1'b0, f_inv);
  endtask
  task automatic t_stall();
    dly <= 8'h0A;
    store(12'hFF0, 1'b0, 12'hF90);
    chkb("boot_page_start", 1'b1, f_start);
    chkb("stall_cpu", 1'b1, stall);
    store(12'hFF0, 1'b0, 12'hFA0);
    chkb("busy_store_reject", 1'b1, st_rej);
    chkb("stall_held", 1'b1, stall);
    wait_done();
    chkb("stall_released", 1'b0, stall);
    dly <= 8'h00;
    store(12'hF80, 1'b1, 12'hC00);
    chkb("edge_page_stall", 1'b1, stall);
    wait_done();
    chkb("prompt_released", 1'b0, stall);
  endtask
  task automatic t_locks();
    wb(1'b1, 8'h04, 32'hE);
    wb(1'b0, 8'h04, 32'h0);
    chk("lock_app_only", 32'hE, rd);
    store(12'hF80, 1'b0, 12'h100);
    chkb("app_locked_store", 1'b1, st_rej);
    wb(1'b1, 8'h04, 32'h7);
    wb(1'b0, 8'h04, 32'h0);
    chk("lock_program_only", 32'h6, rd);
    x_pc <= 12'hF90;
    load(12'h100, 12'hFA0);
    chkb("boot_load_deny", 1'b1, ld_deny);
    chkb("boot_irq_block", 1'b1, irq_blk);
    wb(1'b1, 8'h04, 32'h5);
    vib <= 1'b1;
    x_pc <= 12'h100;
    load(12'hF90, 12'h200);
    chkb("app_load_deny", 1'b1, ld_deny);
    chkb("app_irq_block", 1'b1, irq_blk);
    wb(1'b0, 8'h0C, 32'h0);
    chk("unmapped_read", 32'h0, rd);
    @(posedge clk);
    chip_er <= 1'b1;
    @(posedge clk);
    chip_er <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk("lock_erased", 32'hF, rd);
    tick();
    chkb("irq_open", 1'b0, irq_blk);
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    t_fuses();
    t_app_store();
    t_conc();
    t_stall();
    t_locks();
    tally_and_finish();
  end
endmodule
